// *** fsps_seq.sv ***
// Flash self-programming command sequencer: takes one command at a time,
// drives a block operation on the flash array, answers with an 8-bit status.
// Assumes a flash array controller on clk_sys with a start/done handshake.
`timescale 1ns/1ps
// Function
// - Interrupt during init stops it with 1FH; resume command finishes it.
// - Successful init or resume stores the buffer start address; status 00H.
// - Init returns 05H if configured system frequency is out of range.
// - Mode check returns 00H for high mode pin, 01H for low.
// - No erase reaches the array while the mode pin is low.
// - Blank check covers one block: 00H blank, 1BH not blank.
// - Block commands with out-of-range block return 05H and do nothing.
// - Interrupt aborts block command with 1FH; caller reissues it.
// - Erase clears exactly one block per command, 00H on success.
// - Erase of protected boot block or outside shield window returns 10H.
// - Erase failure during operation returns 1AH.
// - Verify checks margin of one block, not logical data compare.
// - Verify returns 1BH on margin failure, 00H on success.
module fsps_seq (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_code,
    input  wire logic [15:0] cmd_block,
    input  wire logic [19:0] cmd_buf_addr,
    input  wire logic        user_irq,
    input  wire logic        flash_mode_pin,
    input  wire logic [15:0] sys_freq_mhz,
    input  wire logic        boot_rewrite_en,
    input  wire logic [15:0] shield_lo,
    input  wire logic [15:0] shield_hi,
    input  wire logic [15:0] boot_blocks,
    input  wire logic        fl_done,
    input  wire logic        fl_fail,
    output logic             busy,
    output logic             status_valid,
    output logic [7:0]       status,
    output logic [19:0]      data_buf_addr,
    output logic             fl_start,
    output logic             fl_abort,
    output logic [1:0]       fl_op,
    output logic [15:0]      fl_block
);
    fsps_pkg::fsps_state_t state_r;
    logic        mode_high;
    logic        irq_s;
    logic [15:0] init_cnt_r;
    logic [19:0] buf_pend_r;
    logic [2:0]  cmd_r;
    logic        init_started_r;
    logic        cmd_take;
    logic        blk_bad;
    logic        blk_prot;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    fsps_sync u_mode_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (flash_mode_pin),
        .q       (mode_high)
    );

    fsps_sync u_irq_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (user_irq),
        .q       (irq_s)
    );

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Commands arriving while busy are ignored, so only one runs at a time.
    assign cmd_take = cmd_valid && (state_r == fsps_pkg::S_IDLE);
    assign blk_bad  = cmd_block >= fsps_pkg::BLOCK_COUNT;
    assign blk_prot = ((cmd_block < boot_blocks) && !boot_rewrite_en) ||
                      (cmd_block < shield_lo) || (cmd_block > shield_hi);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r        <= fsps_pkg::S_IDLE;
            status         <= fsps_pkg::ST_OK;
            status_valid   <= 1'b0;
            busy           <= 1'b0;
            fl_start       <= 1'b0;
            fl_abort       <= 1'b0;
            fl_op          <= fsps_pkg::FOP_BLANK;
            fl_block       <= 16'h0000;
            cmd_r          <= fsps_pkg::CMD_INIT;
            init_cnt_r     <= 16'h0000;
            buf_pend_r     <= fsps_pkg::BUF_RESET;
            init_started_r <= 1'b0;
        end else begin
            status_valid <= 1'b0;
            fl_start     <= 1'b0;
            fl_abort     <= 1'b0;
            case (state_r)
                fsps_pkg::S_IDLE: begin
                    if (cmd_take) begin
                        busy  <= 1'b1;
                        cmd_r <= cmd_code;
                        state_r <= fsps_pkg::S_DONE;
                        case (cmd_code)
                            fsps_pkg::CMD_INIT, fsps_pkg::CMD_INIT_RES: begin
                                if (sys_freq_mhz < fsps_pkg::FREQ_MIN_MHZ ||
                                    sys_freq_mhz > fsps_pkg::FREQ_MAX_MHZ) begin
                                    status <= fsps_pkg::ST_PARAM;
                                end else if (cmd_code == fsps_pkg::CMD_INIT_RES && !init_started_r) begin
                                    status <= fsps_pkg::ST_CMD_ERR;
                                end else begin
                                    // A fresh init restarts the count; a resume keeps it.
                                    if (cmd_code == fsps_pkg::CMD_INIT) begin
                                        init_cnt_r <= 16'h0000;
                                    end
                                    init_started_r <= 1'b1;
                                    buf_pend_r     <= cmd_buf_addr;
                                    state_r        <= fsps_pkg::S_INIT;
                                end
                            end
                            fsps_pkg::CMD_MODE: begin
                                status <= mode_high ? fsps_pkg::ST_OK : fsps_pkg::ST_MODE_LOW;
                            end
                            fsps_pkg::CMD_BLANK, fsps_pkg::CMD_ERASE, fsps_pkg::CMD_VERIFY: begin
                                if (blk_bad) begin
                                    status <= fsps_pkg::ST_PARAM;
                                end else if (cmd_code == fsps_pkg::CMD_ERASE && blk_prot) begin
                                    status <= fsps_pkg::ST_PROTECT;
                                end else if (cmd_code == fsps_pkg::CMD_ERASE && !mode_high) begin
                                    status <= fsps_pkg::ST_ERASE_ERR;
                                end else begin
                                    fl_start <= 1'b1;
                                    fl_block <= cmd_block;
                                    fl_op    <= (cmd_code == fsps_pkg::CMD_BLANK) ? fsps_pkg::FOP_BLANK :
                                                (cmd_code == fsps_pkg::CMD_ERASE) ? fsps_pkg::FOP_ERASE :
                                                fsps_pkg::FOP_VERIFY;
                                    state_r  <= fsps_pkg::S_FLASH;
                                end
                            end
                            default: begin
                                status <= fsps_pkg::ST_CMD_ERR;
                            end
                        endcase
                    end
                end
                fsps_pkg::S_INIT: begin
                    if (irq_s) begin
                        status  <= fsps_pkg::ST_INTR;
                        state_r <= fsps_pkg::S_DONE;
                    end else if (init_cnt_r == fsps_pkg::INIT_CYCLES) begin
                        status         <= fsps_pkg::ST_OK;
                        init_started_r <= 1'b0;
                        state_r        <= fsps_pkg::S_DONE;
                    end else begin
                        init_cnt_r <= init_cnt_r + 16'h0001;
                    end
                end
                fsps_pkg::S_FLASH: begin
                    if (fl_done) begin
                        state_r <= fsps_pkg::S_DONE;
                        if (!fl_fail) begin
                            status <= fsps_pkg::ST_OK;
                        end else if (cmd_r == fsps_pkg::CMD_ERASE) begin
                            status <= fsps_pkg::ST_ERASE_ERR;
                        end else begin
                            status <= fsps_pkg::ST_BLANK_ERR;
                        end
                    end else if (irq_s || (cmd_r == fsps_pkg::CMD_ERASE && !mode_high)) begin
                        // Losing the mode pin mid-erase stops the array at once.
                        fl_abort <= 1'b1;
                        state_r  <= fsps_pkg::S_ABORT;
                    end
                end
                fsps_pkg::S_ABORT: begin
                    if (fl_done) begin
                        status  <= (cmd_r == fsps_pkg::CMD_ERASE && !mode_high) ?
                                   fsps_pkg::ST_ERASE_ERR : fsps_pkg::ST_INTR;
                        state_r <= fsps_pkg::S_DONE;
                    end
                end
                fsps_pkg::S_DONE: begin
                    busy         <= 1'b0;
                    status_valid <= 1'b1;
                    state_r      <= fsps_pkg::S_IDLE;
                end
                default: begin
                    state_r <= fsps_pkg::S_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

    // The buffer address becomes visible only when init actually completes.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_buf_addr <= fsps_pkg::BUF_RESET;
        end else if (state_r == fsps_pkg::S_INIT && !irq_s && init_cnt_r == fsps_pkg::INIT_CYCLES) begin
            data_buf_addr <= buf_pend_r;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_mode_status;
        @(posedge clk_sys) disable iff (reset)
        (cmd_take && cmd_code == fsps_pkg::CMD_MODE) |=> ##1
            (status_valid && status == (($past(mode_high, 2)) ? fsps_pkg::ST_OK : fsps_pkg::ST_MODE_LOW));
    endproperty
    a_mode_status: assert property (p_mode_status) else $error("mode check status wrong");

    property p_no_erase_low;
        @(posedge clk_sys) disable iff (reset)
        (fl_start && fl_op == fsps_pkg::FOP_ERASE) |-> $past(mode_high);
    endproperty
    a_no_erase_low: assert property (p_no_erase_low) else $error("erase started with mode pin low");

    property p_block_range;
        @(posedge clk_sys) disable iff (reset)
        (cmd_take && cmd_code >= fsps_pkg::CMD_BLANK && cmd_code <= fsps_pkg::CMD_VERIFY && blk_bad) |=>
            !fl_start ##1 (status_valid && status == fsps_pkg::ST_PARAM);
    endproperty
    a_block_range: assert property (p_block_range) else $error("bad block not refused");

    property p_protect;
        @(posedge clk_sys) disable iff (reset)
        (cmd_take && cmd_code == fsps_pkg::CMD_ERASE && !blk_bad && blk_prot) |=>
            !fl_start ##1 (status_valid && status == fsps_pkg::ST_PROTECT);
    endproperty
    a_protect: assert property (p_protect) else $error("protected erase not refused");

    property p_init_intr;
        @(posedge clk_sys) disable iff (reset)
        (state_r == fsps_pkg::S_INIT && irq_s) |=> ##1 (status_valid && status == fsps_pkg::ST_INTR);
    endproperty
    a_init_intr: assert property (p_init_intr) else $error("init interrupt status wrong");

    property p_init_freq;
        @(posedge clk_sys) disable iff (reset)
        (cmd_take && cmd_code == fsps_pkg::CMD_INIT && sys_freq_mhz > fsps_pkg::FREQ_MAX_MHZ) |=>
            ##1 (status_valid && status == fsps_pkg::ST_PARAM);
    endproperty
    a_init_freq: assert property (p_init_freq) else $error("frequency error not reported");

    property p_flash_abort;
        @(posedge clk_sys) disable iff (reset)
        (state_r == fsps_pkg::S_FLASH && !fl_done && irq_s) |=> (fl_abort && state_r == fsps_pkg::S_ABORT);
    endproperty
    a_flash_abort: assert property (p_flash_abort) else $error("interrupt did not abort");

    property p_erase_fail;
        @(posedge clk_sys) disable iff (reset)
        (state_r == fsps_pkg::S_FLASH && fl_done && fl_fail && cmd_r == fsps_pkg::CMD_ERASE) |=>
            ##1 (status_valid && status == fsps_pkg::ST_ERASE_ERR);
    endproperty
    a_erase_fail: assert property (p_erase_fail) else $error("erase failure not reported");

    property p_verify_fail;
        @(posedge clk_sys) disable iff (reset)
        (state_r == fsps_pkg::S_FLASH && fl_done && fl_fail && cmd_r != fsps_pkg::CMD_ERASE) |=>
            ##1 (status_valid && status == fsps_pkg::ST_BLANK_ERR);
    endproperty
    a_verify_fail: assert property (p_verify_fail) else $error("check failure not reported");

    property p_busy_ok;
        @(posedge clk_sys) disable iff (reset)
        cmd_take |=> busy;
    endproperty
    a_busy_ok: assert property (p_busy_ok) else $error("not busy after command");

    property p_no_ok_abort;
        @(posedge clk_sys) disable iff (reset)
        (state_r == fsps_pkg::S_ABORT && fl_done) |=> ##1 (status_valid && status != fsps_pkg::ST_OK);
    endproperty
    a_no_ok_abort: assert property (p_no_ok_abort) else $error("ok reported after abort");

endmodule

// *** fsps_pkg.sv ***
// Package for the flash self-programming sequencer: commands, status codes,
// states and limits.
// Assumes a single clock domain and a flash array model outside the block.
package fsps_pkg;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_INIT     = 3'h0;
    localparam logic [2:0] CMD_INIT_RES = 3'h1;
    localparam logic [2:0] CMD_MODE     = 3'h2;
    localparam logic [2:0] CMD_BLANK    = 3'h3;
    localparam logic [2:0] CMD_ERASE    = 3'h4;
    localparam logic [2:0] CMD_VERIFY   = 3'h5;

    // ------------------------------------------------------------------
    // Status codes
    // ------------------------------------------------------------------
    localparam logic [7:0] ST_OK        = 8'h00;
    localparam logic [7:0] ST_MODE_LOW  = 8'h01;
    localparam logic [7:0] ST_PARAM     = 8'h05;
    localparam logic [7:0] ST_PROTECT   = 8'h10;
    localparam logic [7:0] ST_ERASE_ERR = 8'h1a;
    localparam logic [7:0] ST_BLANK_ERR = 8'h1b;
    localparam logic [7:0] ST_INTR      = 8'h1f;
    localparam logic [7:0] ST_CMD_ERR   = 8'hff;

    // ------------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] BLOCK_COUNT  = 16'h0040;
    localparam logic [15:0] FREQ_MIN_MHZ = 16'h0002;
    localparam logic [15:0] FREQ_MAX_MHZ = 16'h0020;
    localparam logic [15:0] INIT_CYCLES  = 16'h0010;
    localparam logic [19:0] BUF_RESET    = 20'h00000;
    localparam logic [1:0]  SYNC_RESET   = 2'h0;

    // Flash array operation codes.
    localparam logic [1:0] FOP_BLANK  = 2'h0;
    localparam logic [1:0] FOP_ERASE  = 2'h1;
    localparam logic [1:0] FOP_VERIFY = 2'h2;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_INIT  = 5'b00010,
        S_FLASH = 5'b00100,
        S_ABORT = 5'b01000,
        S_DONE  = 5'b10000
    } fsps_state_t;

endpackage

// *** fsps_sync.sv ***
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level such as a mode pin.
`timescale 1ns/1ps
module fsps_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic d,
    output logic      q
);
    logic [1:0] sync_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_r <= fsps_pkg::SYNC_RESET;
        end else begin
            sync_r <= {sync_r[0], d};
        end
    end

    assign q = sync_r[1];
endmodule

// *** fsps_flash_model.sv ***
// Behavioural flash array that answers the sequencer's start/abort port.
// Assumes clk_sys and one operation at a time; erase with fail_en low makes a block blank.
`timescale 1ns/1ps
module fsps_flash_model (
    input  wire logic        clk_sys,
    input  wire logic        fl_start,
    input  wire logic        fl_abort,
    input  wire logic [1:0]  fl_op,
    input  wire logic [15:0] fl_block,
    input  wire logic [7:0]  lat,
    input  wire logic        fail_en,
    output logic             fl_done,
    output logic             fl_fail
);
    logic       blank [64];
    int         cnt;
    logic [1:0] op;
    logic [5:0] blk;

    initial begin
        fl_done = 1'b0;
        fl_fail = 1'b0;
        cnt = 0;
        foreach (blank[i]) blank[i] = 1'b0;
    end

    // Outputs move 1 ns after the edge; fl_fail toggles when it means nothing.
    always @(posedge clk_sys) begin
        #1;
        fl_done = 1'b0;
        fl_fail = ~fl_fail;
        if (fl_start === 1'b1) begin
            op = fl_op;
            blk = fl_block[5:0];
            cnt = lat;
        end else if (cnt > 0 && fl_abort === 1'b1) begin
            cnt = 0;
            fl_done = 1'b1;
            fl_fail = 1'b0;
        end else if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                fl_done = 1'b1;
                case (op)
                    2'h0: fl_fail = ~blank[blk];
                    2'h1: fl_fail = fail_en;
                    default: fl_fail = fail_en;
                endcase
                if (op == 2'h1 && !fail_en) blank[blk] = 1'b1;
            end
        end
    end
endmodule

// *** flash_self_program_sequencer_test.sv ***
// Self-checking bench for the sequencer, with a flash array model behind it.
// Assumes a single 125 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
module flash_self_program_sequencer_test;
    logic clk_sys = 1'b0, reset = 1'b1, cmd_valid = 1'b0, user_irq = 1'b0;
    logic [2:0] cmd_code = 3'h0;
    logic [15:0] cmd_block = 16'h0000, sys_freq_mhz = 16'h0010, boot_blocks = 16'h0004;
    logic [15:0] shield_lo = 16'h0002, shield_hi = 16'h0037;
    logic [19:0] cmd_buf_addr = 20'h00000, data_buf_addr;
    logic flash_mode_pin = 1'b1, boot_rewrite_en = 1'b0, fail_en = 1'b0;
    logic fl_done, fl_fail, busy, status_valid, fl_start, fl_abort;
    logic [7:0] status, lat = 8'h04;
    logic [1:0] fl_op, last_op;
    logic [15:0] fl_block, last_blk;
    logic mir [64];
    int error_cnt = 0, checks_done = 0, starts = 0, cyc = 0, aborts = 0;
    logic [19:0] a;
    logic [7:0] e;

    fsps_seq u_fsps_seq (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_block(cmd_block), .cmd_buf_addr(cmd_buf_addr), .user_irq(user_irq),
        .flash_mode_pin(flash_mode_pin), .sys_freq_mhz(sys_freq_mhz), .boot_rewrite_en(boot_rewrite_en),
        .shield_lo(shield_lo), .shield_hi(shield_hi), .boot_blocks(boot_blocks), .fl_done(fl_done),
        .fl_fail(fl_fail), .busy(busy), .status_valid(status_valid), .status(status),
        .data_buf_addr(data_buf_addr), .fl_start(fl_start), .fl_abort(fl_abort), .fl_op(fl_op),
        .fl_block(fl_block));
    fsps_flash_model u_fsps_flash_model (.clk_sys(clk_sys), .fl_start(fl_start), .fl_abort(fl_abort),
        .fl_op(fl_op), .fl_block(fl_block), .lat(lat), .fail_en(fail_en), .fl_done(fl_done),
        .fl_fail(fl_fail));

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (fl_start === 1'b1) begin
            starts++;
            last_blk = fl_block;
            last_op = fl_op;
        end
        if (fl_abort === 1'b1) aborts++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // Reference model and transfer tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] model(input int c, input int b);
        if (c == 2) return flash_mode_pin ? 8'h00 : 8'h01;
        if (c == 0) return (sys_freq_mhz < 2 || sys_freq_mhz > 32) ? 8'h05 : 8'h00;
        if (c < 2 || c > 5) return 8'hff;
        if (b > 63) return 8'h05;
        if (c == 4 && ((b < boot_blocks && !boot_rewrite_en) || b < shield_lo || b > shield_hi))
            return 8'h10;
        if (c == 4) return (!flash_mode_pin || fail_en) ? 8'h1a : 8'h00;
        if (c == 3) return mir[b] ? 8'h00 : 8'h1b;
        return fail_en ? 8'h1b : 8'h00;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Issues one command while idle; irq_at raises the user interrupt that many cycles in.
    task automatic run(input logic [2:0] c, input logic [15:0] b, input logic [19:0] ad,
                       input int irq_at, input logic [7:0] exp);
        int n;
        int s0;
        int ns;
        int ab0;
        s0 = starts;
        ab0 = aborts;
        ns = (c >= 3 && c <= 5 && exp != 8'h05 && exp != 8'h10 && !(c == 4 && !flash_mode_pin));
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_block = b;
        cmd_buf_addr = ad;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        cmd_block = ~b;
        cmd_buf_addr = ~ad;
        chk(busy, 1);
        n = 0;
        while (status_valid !== 1'b1 && n < 300) begin
            n++;
            if (n == irq_at) user_irq = 1'b1;
            @(posedge clk_sys);
            #1;
        end
        chk(status_valid, 1);
        chk(busy, 0);
        chk(status, exp);
        chk(starts - s0, ns);
        if (ns) chk(last_blk, b);
        if (ns) chk(last_op, (c == 3) ? 0 : (c == 4) ? 1 : 2);
        chk(aborts - ab0, ns && (exp == 8'h1f || (c == 4 && exp == 8'h1a && !flash_mode_pin)));
        if (c == 4 && exp == 8'h00) mir[b] = 1'b1;
        user_irq = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(status_valid, 0);
    endtask

    task automatic op(input int c, input int b);
        run(c[2:0], b[15:0], 20'h00000, 0, model(c, b));
    endtask

    task automatic stop_test();
        $display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int fr [4] = '{1, 2, 32, 33};
        foreach (mir[i]) mir[i] = 1'b0;
        void'($urandom(71385));
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        foreach (fr[i]) begin
            sys_freq_mhz = 16'(fr[i]);
            a = 20'($urandom);
            run(3'h0, 16'h0000, a, 0, model(0, 0));
            if (fr[i] == 32) chk(data_buf_addr, a);
        end
        // The last frequency tried is out of range; restore a legal one first.
        sys_freq_mhz = 16'h0010;
        run(3'h1, 16'h0000, 20'h00123, 0, 8'hff);
        run(3'h0, 16'h0000, 20'h00456, 5, 8'h1f);
        a = 20'($urandom);
        run(3'h1, 16'h0000, a, 0, 8'h00);
        chk(data_buf_addr, a);
        $display("init tests done");
        op(2, 0);
        flash_mode_pin = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        op(2, 0);
        op(4, 10);
        flash_mode_pin = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        op(6, 0);
        op(7, 0);
        $display("mode tests done");
        for (int c = 3; c <= 5; c++) begin
            op(c, 64);
            op(c, 16'hffff);
        end
        op(3, 10);
        op(4, 10);
        op(3, 10);
        op(4, 3);
        op(4, 1);
        op(4, 60);
        boot_rewrite_en = 1'b1;
        op(4, 3);
        fail_en = 1'b1;
        op(4, 20);
        op(5, 20);
        fail_en = 1'b0;
        op(5, 20);
        $display("block tests done");
        lat = 8'h14;
        for (int c = 3; c <= 5; c++) begin
            run(c[2:0], 16'h001e, 20'h00000, 3, 8'h1f);
            op(c, 30);
        end
        // Dropping the mode pin in mid-erase must stop the array and report an erase error.
        fork
            run(3'h4, 16'h001f, 20'h00000, 0, 8'h1a);
            begin
                repeat (3) @(posedge clk_sys);
                #1;
                flash_mode_pin = 1'b0;
            end
        join
        flash_mode_pin = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        $display("interrupt tests done");
        for (int i = 0; i < 16; i++) begin
            lat = 8'(1 + $urandom % 8);
            fail_en = 1'($urandom % 2);
            op(3 + $urandom % 3, $urandom % 70);
        end
        $display("random tests done");
        stop_test();
    end
endmodule
